// ==== rdl_device.sv ====
`timescale 1ns/1ps
module rdl_device
  import rdl_pkg::*;
(
  rdl_link_if.device link,
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_fb_div,
  output logic o_pump_out,
  output logic o_pump_oe_n,
  output logic o_ref_div_out,
  output logic [LATCH_W-1:0] o_config
);
  typedef struct packed {
    logic [FRAME_W-1:0] shift;
  } rdl_link_st_t;
  typedef struct packed {
    logic [LATCH_W-1:0] latch;
    logic [RATIO_W-1:0] cnt;
    logic strobe_d;
    logic fb_d;
    logic ref_out;
    logic up;
    logic dn;
    logic pump_out;
    logic pump_oe_n;
  } rdl_dev_st_t;

  rdl_link_st_t lk_ff;
  rdl_link_st_t nxt_lk;
  rdl_dev_st_t st_ff;
  rdl_dev_st_t nxt_st;
  logic [1:0] synced;
  logic strobe_s;
  logic fb_s;
  logic ref_pulse;
  logic fb_edge;
  logic pos;
  logic pu;
  logic pd;

  // Each bit enters at bit 0 and moves toward the top.
  always_comb begin
    nxt_lk.shift = {lk_ff.shift[FRAME_W-2:0], link.sdata};
  end

  always_ff @(posedge link.sclk) begin
    lk_ff <= nxt_lk;
  end

  rdl_sync #(.W(2)) rdl_sync_inst (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({link.load_strobe, i_fb_div}),
    .o_sync(synced)
  );
  assign strobe_s = synced[1];
  assign fb_s = synced[0];

  // The shift register is quiet while the strobe is high, so it is read here after the strobe is synchronised.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobe_d = strobe_s;
    nxt_st.fb_d = fb_s;
    fb_edge = fb_s & ~st_ff.fb_d;
    if (strobe_s && !st_ff.strobe_d && lk_ff.shift[ADDR_BIT] == ADDR_REF) begin
      nxt_st.latch = lk_ff.shift[LATCH_W:1];
    end
    ref_pulse = 1'b0;
    if (st_ff.cnt <= 10'h001) begin
      nxt_st.cnt = st_ff.latch[RATIO_W-1:0];
      ref_pulse = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt - 10'h001;
    end
    nxt_st.ref_out = ref_pulse;
    if (st_ff.latch[HIZ_BIT]) begin
      nxt_st.up = 1'b0;
      nxt_st.dn = 1'b0;
    end else if (st_ff.up && st_ff.dn) begin
      nxt_st.up = 1'b0;
      nxt_st.dn = 1'b0;
    end else begin
      nxt_st.up = st_ff.up | ref_pulse;
      nxt_st.dn = st_ff.dn | fb_edge;
    end
    pos = st_ff.latch[POL_BIT];
    pu = pos ? st_ff.up : st_ff.dn;
    pd = pos ? st_ff.dn : st_ff.up;
    if (st_ff.latch[TEST_BIT]) begin
      nxt_st.pump_out = pos ? fb_s : st_ff.ref_out;
      nxt_st.pump_oe_n = 1'b0;
    end else if (st_ff.latch[HIZ_BIT]) begin
      nxt_st.pump_out = 1'b0;
      nxt_st.pump_oe_n = 1'b1;
    end else begin
      nxt_st.pump_out = pu;
      nxt_st.pump_oe_n = ~(pu | pd);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_ff <= '{latch: LATCH_RST, cnt: '0, pump_oe_n: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_pump_out = st_ff.pump_out;
  assign o_pump_oe_n = st_ff.pump_oe_n;
  assign o_ref_div_out = st_ff.ref_out;
  assign o_config = st_ff.latch;
endmodule // rdl_device

// ==== rdl_host.sv ====
`timescale 1ns/1ps
module rdl_host
  import rdl_pkg::*;
(
  rdl_link_if.host link,
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);
  typedef struct packed {
    rdl_host_state_t state;
    logic [FRAME_W-1:0] frame;
    logic [FRAME_W-1:0] shreg;
    logic [4:0] bit_cnt;
    logic [3:0] tmr;
    logic sclk;
    logic sdata;
    logic le;
    logic busy;
    logic refused;
    logic ack;
    logic [31:0] rdata;
  } rdl_host_st_t;

  rdl_host_st_t st_ff;
  rdl_host_st_t nxt_st;
  logic req;
  logic wr;
  logic go;
  logic [FRAME_W-1:0] f;

  always_comb begin
    nxt_st = st_ff;
    req = i_wb_cyc & i_wb_stb & ~st_ff.ack;
    // A write lands at the edge where the master samples ack, while its data still stands.
    wr = i_wb_cyc & i_wb_stb & i_wb_we & st_ff.ack;
    go = 1'b0;
    f = st_ff.frame;
    nxt_st.ack = req;
    nxt_st.rdata = 32'h0000_0000;
    if (req && !i_wb_we) begin
      if (i_wb_adr == ADR_FRAME) begin
        nxt_st.rdata = {14'h0000, st_ff.frame};
      end else if (i_wb_adr == ADR_STATUS) begin
        nxt_st.rdata[STAT_BUSY_BIT] = st_ff.busy;
        nxt_st.rdata[STAT_REFUSED_BIT] = st_ff.refused;
      end
    end
    if (wr && i_wb_adr == ADR_FRAME) begin
      if (i_wb_sel[0]) nxt_st.frame[7:0] = i_wb_dat[7:0];
      if (i_wb_sel[1]) nxt_st.frame[15:8] = i_wb_dat[15:8];
      if (i_wb_sel[2]) nxt_st.frame[17:16] = i_wb_dat[17:16];
    end else if (wr && i_wb_adr == ADR_CTRL && i_wb_sel[0]) begin
      go = i_wb_dat[CTRL_GO_BIT];
    end
    if (f[ADDR_BIT] == ADDR_REF) begin
      f[RSV_BIT+1] = 1'b0;
      if (f[TEST_BIT+1]) begin
        f[HIZ_BIT+1] = 1'b1;
      end
    end
    case (st_ff.state)
      ST_IDLE: begin
        if (go && !st_ff.busy) begin
          if (f[ADDR_BIT] == ADDR_REF && f[RATIO_W:1] < RATIO_MIN) begin
            nxt_st.refused = 1'b1;
          end else begin
            nxt_st.refused = 1'b0;
            nxt_st.busy = 1'b1;
            nxt_st.sdata = f[FRAME_W-1];
            nxt_st.shreg = {f[FRAME_W-2:0], 1'b0};
            nxt_st.bit_cnt = 5'(FRAME_W - 1);
            nxt_st.tmr = 4'(LINK_HALF_CYC - 1);
            nxt_st.state = ST_SHIFT_LO;
          end
        end
      end
      ST_SHIFT_LO: begin
        if (st_ff.tmr == 4'h0) begin
          nxt_st.sclk = 1'b1;
          nxt_st.tmr = 4'(LINK_HALF_CYC - 1);
          nxt_st.state = ST_SHIFT_HI;
        end else begin
          nxt_st.tmr = st_ff.tmr - 4'h1;
        end
      end
      ST_SHIFT_HI: begin
        if (st_ff.tmr == 4'h0) begin
          nxt_st.sclk = 1'b0;
          nxt_st.tmr = 4'(LINK_HALF_CYC - 1);
          if (st_ff.bit_cnt == 5'h00) begin
            nxt_st.state = ST_LOAD_WAIT;
          end else begin
            nxt_st.bit_cnt = st_ff.bit_cnt - 5'h01;
            nxt_st.sdata = st_ff.shreg[FRAME_W-1];
            nxt_st.shreg = {st_ff.shreg[FRAME_W-2:0], 1'b0};
            nxt_st.state = ST_SHIFT_LO;
          end
        end else begin
          nxt_st.tmr = st_ff.tmr - 4'h1;
        end
      end
      ST_LOAD_WAIT: begin
        if (st_ff.tmr == 4'h0) begin
          nxt_st.le = 1'b1;
          nxt_st.tmr = 4'(STROBE_CYC - 1);
          nxt_st.state = ST_LOAD;
        end else begin
          nxt_st.tmr = st_ff.tmr - 4'h1;
        end
      end
      ST_LOAD: begin
        if (st_ff.tmr == 4'h0) begin
          nxt_st.le = 1'b0;
          nxt_st.tmr = 4'(STROBE_CYC - 1);
          nxt_st.state = ST_GAP;
        end else begin
          nxt_st.tmr = st_ff.tmr - 4'h1;
        end
      end
      ST_GAP: begin
        if (st_ff.tmr == 4'h0) begin
          nxt_st.busy = 1'b0;
          nxt_st.state = ST_IDLE;
        end else begin
          nxt_st.tmr = st_ff.tmr - 4'h1;
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_ff <= '{state: ST_IDLE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.sclk = st_ff.sclk;
  assign link.sdata = st_ff.sdata;
  assign link.load_strobe = st_ff.le;
  assign o_wb_dat = st_ff.rdata;
  assign o_wb_ack = st_ff.ack;
endmodule // rdl_host

// ==== rdl_link_if.sv ====
`timescale 1ns/1ps
interface rdl_link_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  modport host (output sclk, output sdata, output load_strobe);
  modport device (input sclk, input sdata, input load_strobe);
endinterface

// ==== rdl_pkg.sv ====
package rdl_pkg;
  localparam int FRAME_W = 18;
  localparam int LATCH_W = 14;
  localparam int RATIO_W = 10;
  localparam int HIZ_BIT = 10;
  localparam int POL_BIT = 11;
  localparam int RSV_BIT = 12;
  localparam int TEST_BIT = 13;
  localparam int ADDR_BIT = 0;
  localparam logic ADDR_REF = 1'b1;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 10'h002;
  localparam logic [LATCH_W-1:0] LATCH_RST = 14'h0400;
  localparam logic [7:0] ADR_FRAME = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam int SYS_CLK_NS = 20;
  localparam int LINK_HALF_NS = 40;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  typedef enum logic [2:0] {ST_IDLE, ST_SHIFT_LO, ST_SHIFT_HI, ST_LOAD_WAIT, ST_LOAD, ST_GAP} rdl_host_state_t;
endpackage

// ==== rdl_props.sv ====
`timescale 1ns/1ps
module rdl_props
  import rdl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_load_strobe,
  input wire logic [LATCH_W-1:0] i_config,
  input wire logic i_pump_oe_n,
  input wire logic i_pump_out,
  input wire logic i_ref_div
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence strobe_pulse_s;
    i_load_strobe [*5] ##1 !i_load_strobe;
  endsequence
  sequence sclk_high_s;
    i_sclk [*2] ##1 !i_sclk;
  endsequence
  data_setup_a: assert property ($changed(i_sdata) |-> !i_sclk)
    else $error("serial data moved while clock high");
  sclk_pulse_a: assert property ($rose(i_sclk) |-> sclk_high_s)
    else $error("serial clock high phase wrong");
  strobe_len_a: assert property ($rose(i_load_strobe) |-> strobe_pulse_s)
    else $error("load strobe width wrong");
  strobe_quiet_a: assert property (i_load_strobe |-> !i_sclk)
    else $error("serial clock high during strobe");
  load_cause_a: assert property ($changed(i_config) |->
    $past(i_load_strobe, 2) || $past(i_load_strobe, 3) || $past(i_load_strobe, 4))
    else $error("config changed without strobe");
  ratio_min_a: assert property ($changed(i_config) |-> i_config[RATIO_W-1:0] >= RATIO_MIN)
    else $error("ratio below minimum loaded");
  reserved_zero_a: assert property (!i_config[RSV_BIT])
    else $error("reserved bit set");
  test_hiz_a: assert property (i_config[TEST_BIT] |-> i_config[HIZ_BIT])
    else $error("test mode without float bit");
  pump_float_a: assert property (!i_config[TEST_BIT] && i_config[HIZ_BIT] |=> i_pump_oe_n)
    else $error("pump driven while floated");
  test_drive_a: assert property (i_config[TEST_BIT] |=> !i_pump_oe_n)
    else $error("pump not driven in test mode");
  test_route_a: assert property (i_config[TEST_BIT] && !i_config[POL_BIT] |=> i_pump_out == $past(i_ref_div))
    else $error("reference divider not routed to pump");
endmodule // rdl_props

// ==== rdl_sync.sv ====
`timescale 1ns/1ps
module rdl_sync #(
  parameter int W = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rdl_sync_st_t;
  rdl_sync_st_t st_ff;
  rdl_sync_st_t nxt_st;

  always_comb begin
    nxt_st.s1 = i_async;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sync = st_ff.s2;
endmodule // rdl_sync

// ==== reference_divider_config_latch_bench.sv ====
`timescale 1ns/1ps
module reference_divider_config_latch_bench;
  import rdl_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic fb = 1'b0;
  logic fb_run = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic [31:0] rd;
  logic ack;
  logic pump_out;
  logic pump_oe_n;
  logic ref_div;
  logic [LATCH_W-1:0] cfg;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #10 i_sys_clk = ~i_sys_clk;
  rdl_link_if rdl_link_if_inst ();
  rdl_host rdl_host_inst (.link(rdl_link_if_inst.host), .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(wb_rdat),
    .o_wb_ack(ack));
  rdl_device rdl_device_inst (.link(rdl_link_if_inst.device), .i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_fb_div(fb), .o_pump_out(pump_out), .o_pump_oe_n(pump_oe_n), .o_ref_div_out(ref_div), .o_config(cfg));
  rdl_props rdl_props_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sclk(rdl_link_if_inst.sclk),
    .i_sdata(rdl_link_if_inst.sdata), .i_load_strobe(rdl_link_if_inst.load_strobe), .i_config(cfg),
    .i_pump_oe_n(pump_oe_n), .i_pump_out(pump_out), .i_ref_div(ref_div));
  task test_done;
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cmp_dat(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_cfg(input logic [LATCH_W-1:0] exp);
    checks++;
    if (cfg !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, cfg, exp);
    end
  endtask
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (fb_run && cycles % 7 == 0) fb <= ~fb;
    if (cycles == 20000) begin
      errors++;
      test_done;
    end
  end
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_sys_clk); while (ack !== 1'b1);
    rd = wb_rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Writes a frame, starts it and polls until the host is idle again.
  task send(input logic [17:0] f);
    wb(1'b1, ADR_FRAME, {14'h0000, f});
    wb(1'b1, ADR_CTRL, 32'h0000_0001);
    do wb(1'b0, ADR_STATUS, 32'h0000_0000); while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task t_regs;
    cmp_cfg(LATCH_RST);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    cmp_dat(rd, 32'h0000_0000);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    cmp_dat(rd, 32'h0000_0000);
  endtask
  task t_load;
    send({17'h1_C807, 1'b1});
    cmp_cfg(14'h0807);
    do @(posedge i_sys_clk); while (ref_div !== 1'b1);
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (ref_div !== 1'b1);
    cmp_dat(n, 32'h0000_0007);
  endtask
  task t_hold;
    send({17'h0_0155, 1'b0});
    cmp_cfg(14'h0807);
    send({17'h0_0001, 1'b1});
    cmp_dat(rd, 32'h0000_0002);
    cmp_cfg(14'h0807);
  endtask
  task t_pump;
    send({17'h0_0402, 1'b1});
    repeat (2) @(posedge i_sys_clk);
    cmp_dat({31'h0000_0000, pump_oe_n}, 32'h0000_0001);
    send({17'h0_3003, 1'b1});
    cmp_cfg(14'h2403);
    repeat (2) @(posedge i_sys_clk);
    cmp_dat({31'h0000_0000, pump_oe_n}, 32'h0000_0000);
    do @(posedge i_sys_clk); while (pump_out !== 1'b1);
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (pump_out !== 1'b1);
    cmp_dat(n, 32'h0000_0003);
  endtask
  // With the feedback input held still only reference pulses set the detector, so polarity decides the pump level.
  task t_pol;
    fb_run <= 1'b0;
    send({17'h0_0802, 1'b1});
    cmp_dat({31'h0000_0000, pump_out}, 32'h0000_0001);
    cmp_dat({31'h0000_0000, pump_oe_n}, 32'h0000_0000);
    send({17'h0_0002, 1'b1});
    cmp_dat({31'h0000_0000, pump_out}, 32'h0000_0000);
    send({17'h0_2C02, 1'b1});
    cmp_cfg(14'h2C02);
    cmp_dat({31'h0000_0000, pump_out}, {31'h0000_0000, fb});
    fb_run <= 1'b1;
  endtask
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    t_regs;
    t_load;
    t_hold;
    t_pump;
    t_pol;
    test_done;
  end
endmodule // reference_divider_config_latch_bench
